// [hw/adc_ctrl_pkg.sv]
// Shared constants and types of the converter control block
package adc_ctrl_pkg;
  // Register byte addresses
  localparam int unsigned ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_EXCITE = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = 5'h10;

  localparam int unsigned RESULT_W = 16;
  localparam int unsigned CFG_W = 13;
  localparam int unsigned EXC_W = 6;

  // Configuration word, low bit first: select, gain, bypass, rate, turbo, continuous
  typedef struct packed {
    logic continuous;
    logic turbo;
    logic [2:0] rate;
    logic amp_bypass_bit;
    logic [2:0] gain;
    logic [3:0] input_select_field;
  } cfg_t;

  // Excitation routing: 0 off, 1..4 analog_input_pin 0..3, 5 pair0 positive, 6 pair0 negative
  typedef struct packed {
    logic [2:0] src1_route;
    logic [2:0] src0_route;
  } exc_t;

  localparam cfg_t CFG_RESET = cfg_t'(13'h0000);
  localparam exc_t EXC_RESET = exc_t'(6'h00);

  // Status bit positions
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_READY = 1;
  localparam int unsigned STAT_LOW_POWER = 2;
  localparam int unsigned STAT_BYPASS = 3;

  // Command codes, low three bits of the command word
  localparam logic [2:0] CMD_RESET = 3'h1;
  localparam logic [2:0] CMD_START = 3'h2;
  localparam logic [2:0] CMD_POWERDOWN = 3'h3;
  localparam logic [2:0] CMD_READ_DATA = 3'h4;
  localparam logic [2:0] CMD_READ_REG = 3'h5;
  localparam logic [2:0] CMD_WRITE_REG = 3'h6;

  // Input select codes: 0..7 differential, 8..B single-ended, C and D monitors
  localparam logic [3:0] SEL_SE_FIRST = 4'h8;
  localparam logic [3:0] SEL_SE_LAST = 4'hB;
  localparam logic [3:0] SEL_MON_REF = 4'hC;
  localparam logic [3:0] SEL_MON_SUPPLY = 4'hD;
  localparam logic [2:0] GAIN_BYPASS_MAX = 3'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Serial idle timeout, in modulator periods and in core cycles
  localparam longint unsigned CLK_PERIOD_PS = 10000;
  localparam longint unsigned MOD_PERIOD_NORMAL_PS = 3906250;
  localparam longint unsigned MOD_PERIOD_TURBO_PS = 1953125;
  localparam longint unsigned TMO_MODS_NORMAL = 13955;
  localparam longint unsigned TMO_MODS_TURBO = 27910;
  localparam int unsigned TMO_W = 23;
  localparam logic [TMO_W-1:0] TMO_CYC_NORMAL =
    TMO_W'((TMO_MODS_NORMAL * MOD_PERIOD_NORMAL_PS) / CLK_PERIOD_PS);
  localparam logic [TMO_W-1:0] TMO_CYC_TURBO =
    TMO_W'((TMO_MODS_TURBO * MOD_PERIOD_TURBO_PS) / CLK_PERIOD_PS);

  typedef enum logic {ST_IDLE, ST_CONV} conv_state_t;
endpackage

// [hw/result_hold.sv]
`timescale 1ns/1ps
// Word register that takes a whole result at one edge
module result_hold #(
  parameter int unsigned W = 16
) (
  // Clock and control
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic load_i,
  // Data
  input wire logic [W-1:0] data_i,
  output logic [W-1:0] data_o
);
  logic [W-1:0] data_r;
  logic [W-1:0] data_nxt;

  // Whole-word load, so a reader never sees a mix of two results
  always_comb begin
    data_nxt = data_r;
    if (load_i) begin
      data_nxt = data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      data_r <= '0;
    end else if (ce_i) begin
      data_r <= data_nxt;
    end
  end

  assign data_o = data_r;
endmodule // result_hold

// [hw/adc_ctrl.sv]
`timescale 1ns/1ps
// Conversion sequencing, result buffer and input configuration behind AXI4-Lite
// Summary of operation
// - All settings sit in two registers; of six command codes on the command port, only reset, start and powerdown act.
// - In single-shot mode a start command runs exactly one conversion whose result is buffered.
// - After a single-shot conversion the device falls back to its low-power idle state.
// - In continuous mode a new conversion starts at once when the previous one ends.
// - In continuous mode results arrive at the programmed output data rate.
// - The result buffer can be read at any time and always holds the last complete result.
// - A 4-bit input select field picks single-ended inputs, differential pairs or a mix.
// - A single-ended selection ties the negative converter input to the negative supply.
// - The select field also offers supply difference over 4 and reference difference over 4.
// - Each of the two excitation sources can go to any analog pin or to either pair-0 reference pin.
// - A 3-bit gain field selects a power-of-two gain from 1 to 128.
// - Full scale equals plus or minus the reference divided by the selected gain.
// - Each result is a 16-bit code proportional to the differential input.
// - The amplifier bypass bit takes effect only at gains 1, 2 and 4.
// - An incomplete command older than the modulator timeout is discarded.
module adc_ctrl #(
  parameter logic [adc_ctrl_pkg::TMO_W-1:0] TMO_NORMAL_CYC = adc_ctrl_pkg::TMO_CYC_NORMAL,
  parameter logic [adc_ctrl_pkg::TMO_W-1:0] TMO_TURBO_CYC = adc_ctrl_pkg::TMO_CYC_TURBO
) (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // AXI4-Lite write
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  // AXI4-Lite read
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // Modulator and filter
  input wire logic conv_done_i,
  input wire logic [adc_ctrl_pkg::RESULT_W-1:0] conv_data_i,
  output logic conv_start_o,
  output logic conv_run_o,
  output logic low_power_o,
  output logic [2:0] rate_o,
  output logic turbo_o,
  // Analog front end
  output logic [3:0] input_select_o,
  output logic neg_to_supply_o,
  output logic mon_supply_o,
  output logic mon_ref_o,
  output logic [2:0] gain_o,
  output logic amp_bypass_o,
  output logic [2:0] exc0_route_o,
  output logic [2:0] exc1_route_o
);
  import adc_ctrl_pkg::*;

  logic aw_held_r, aw_held_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic w_held_r, w_held_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [TMO_W-1:0] tmo_cnt_r, tmo_cnt_nxt;
  cfg_t cfg_r, cfg_nxt;
  exc_t exc_r, exc_nxt;
  conv_state_t state_r, state_nxt;
  logic start_r, start_nxt;
  logic ready_r, ready_nxt;
  logic cmd_start, cmd_stop, cmd_reset, res_read, load;
  logic bypass_eff;
  logic [TMO_W-1:0] tmo_limit;
  logic [RESULT_W-1:0] result;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Readies drop with ce_i so nothing is taken while state is frozen
  assign awready_o = ce_i && !aw_held_r && !bvalid_r;
  assign wready_o = ce_i && !w_held_r && !bvalid_r;
  assign arready_o = ce_i && !rvalid_r;
  assign bvalid_o = bvalid_r;
  assign bresp_o = bresp_r;
  assign rvalid_o = rvalid_r;
  assign rdata_o = rdata_r;
  assign rresp_o = rresp_r;

  assign bypass_eff = cfg_r.amp_bypass_bit && (cfg_r.gain <= GAIN_BYPASS_MAX);
  assign tmo_limit = cfg_r.turbo ? TMO_TURBO_CYC : TMO_NORMAL_CYC;

  // Bus slave, registers and command decode
  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    tmo_cnt_nxt = '0;
    cfg_nxt = cfg_r;
    exc_nxt = exc_r;
    cmd_start = 1'b0;
    cmd_stop = 1'b0;
    cmd_reset = 1'b0;
    res_read = 1'b0;
    if (bvalid_r && bready_i) begin
      bvalid_nxt = 1'b0;
    end
    if (awvalid_i && awready_o) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      w_held_nxt = 1'b1;
      w_data_nxt = wdata_i;
      w_strb_nxt = wstrb_i;
    end
    // Half a command waits only so long, then the port starts afresh
    if (aw_held_r != w_held_r) begin
      if (tmo_cnt_r >= tmo_limit - 1'b1) begin
        aw_held_nxt = 1'b0;
        w_held_nxt = 1'b0;
      end else begin
        tmo_cnt_nxt = tmo_cnt_r + 1'b1;
      end
    end
    if (aw_held_r && w_held_r) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (aw_addr_r == ADDR_CONFIG) begin
        cfg_nxt = cfg_t'(CFG_W'(merge_bytes(32'(cfg_r), w_data_r, w_strb_r)));
      end else if (aw_addr_r == ADDR_EXCITE) begin
        exc_nxt = exc_t'(EXC_W'(merge_bytes(32'(exc_r), w_data_r, w_strb_r)));
      end else if (aw_addr_r == ADDR_COMMAND) begin
        // Register reads and writes go over the bus itself, so those codes only acknowledge
        if (w_strb_r[0]) begin
          cmd_start = (w_data_r[2:0] == CMD_START);
          cmd_stop = (w_data_r[2:0] == CMD_POWERDOWN);
          cmd_reset = (w_data_r[2:0] == CMD_RESET);
        end
        if (cmd_reset) begin
          cfg_nxt = CFG_RESET;
          exc_nxt = EXC_RESET;
        end
      end else if (aw_addr_r != ADDR_STATUS && aw_addr_r != ADDR_RESULT) begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    if (rvalid_r && rready_i) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid_i && arready_o) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (araddr_i == ADDR_CONFIG) begin
        rdata_nxt = 32'(cfg_r);
      end else if (araddr_i == ADDR_EXCITE) begin
        rdata_nxt = 32'(exc_r);
      end else if (araddr_i == ADDR_STATUS) begin
        rdata_nxt[STAT_BUSY] = (state_r == ST_CONV);
        rdata_nxt[STAT_READY] = ready_r;
        rdata_nxt[STAT_LOW_POWER] = (state_r == ST_IDLE);
        rdata_nxt[STAT_BYPASS] = bypass_eff;
      end else if (araddr_i == ADDR_RESULT) begin
        rdata_nxt = 32'(result);
        res_read = 1'b1;
      end else if (araddr_i != ADDR_COMMAND) begin
        rresp_nxt = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
      tmo_cnt_r <= '0;
      cfg_r <= CFG_RESET;
      exc_r <= EXC_RESET;
    end else if (ce_i) begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      tmo_cnt_r <= tmo_cnt_nxt;
      cfg_r <= cfg_nxt;
      exc_r <= exc_nxt;
    end
  end

  // Conversion sequencer
  always_comb begin
    state_nxt = state_r;
    start_nxt = 1'b0;
    ready_nxt = ready_r;
    load = (state_r == ST_CONV) && conv_done_i;
    case (state_r)
      ST_IDLE: begin
        if (cmd_start) begin
          state_nxt = ST_CONV;
          start_nxt = 1'b1;
        end
      end
      ST_CONV: begin
        if (cmd_stop || cmd_reset) begin
          state_nxt = ST_IDLE;
        end else if (cmd_start) begin
          start_nxt = 1'b1;
        end else if (conv_done_i) begin
          if (cfg_r.continuous) begin
            start_nxt = 1'b1;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // A result landing during its own read keeps the flag set
    if (res_read || cmd_reset) begin
      ready_nxt = 1'b0;
    end
    if (load) begin
      ready_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      start_r <= 1'b0;
      ready_r <= 1'b0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      start_r <= start_nxt;
      ready_r <= ready_nxt;
    end
  end

  result_hold #(.W(RESULT_W)) u_result (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .load_i(load),
    .data_i(conv_data_i),
    .data_o(result)
  );

  assign conv_start_o = start_r;
  assign conv_run_o = (state_r == ST_CONV);
  assign low_power_o = (state_r == ST_IDLE);
  assign rate_o = cfg_r.rate;
  assign turbo_o = cfg_r.turbo;
  assign input_select_o = cfg_r.input_select_field;
  assign neg_to_supply_o = (cfg_r.input_select_field >= SEL_SE_FIRST) &&
                           (cfg_r.input_select_field <= SEL_SE_LAST);
  assign mon_ref_o = (cfg_r.input_select_field == SEL_MON_REF);
  assign mon_supply_o = (cfg_r.input_select_field == SEL_MON_SUPPLY);
  // Full scale is reference over gain; the filter scales with this code
  assign gain_o = cfg_r.gain;
  assign amp_bypass_o = bypass_eff;
  assign exc0_route_o = exc_r.src0_route;
  assign exc1_route_o = exc_r.src1_route;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  logic cfg_wr;
  assign cfg_wr = ce_i && aw_held_r && w_held_r && aw_addr_r == ADDR_CONFIG && (&w_strb_r);
  sequence conv_end_s;
    ce_i && state_r == ST_CONV && conv_done_i && !cmd_start && !cmd_stop && !cmd_reset;
  endsequence

  start_runs_conv_a: assert property (ce_i && state_r == ST_IDLE && cmd_start
    |=> state_r == ST_CONV && conv_start_o ##1 !conv_start_o || !ce_i)
    else $error("start command did not begin a conversion");
  single_goes_idle_a: assert property (conv_end_s and !cfg_r.continuous
    |=> low_power_o && !conv_run_o)
    else $error("single-shot did not return to idle");
  cont_restarts_a: assert property (conv_end_s and cfg_r.continuous
    |=> conv_start_o && conv_run_o)
    else $error("continuous mode did not restart");
  rate_follows_a: assert property (cfg_wr |=> rate_o == $past(w_data_r[10:8]))
    else $error("programmed rate not applied");
  result_load_a: assert property (ce_i && load |=> result == $past(conv_data_i)
    and ready_r)
    else $error("result buffer missed a conversion");
  result_steady_a: assert property (!load |=> $stable(result))
    else $error("result changed without a completed conversion");
  single_ended_a: assert property (cfg_wr && w_data_r[3:0] >= SEL_SE_FIRST
    && w_data_r[3:0] <= SEL_SE_LAST |=> neg_to_supply_o && !mon_ref_o)
    else $error("single-ended input left negative node open");
  gain_field_a: assert property (cfg_wr |=> gain_o == $past(w_data_r[6:4]))
    else $error("gain field not applied");
  bypass_gain_a: assert property (amp_bypass_o |-> gain_o <= GAIN_BYPASS_MAX)
    else $error("bypass active above gain 4");
  timeout_drop_a: assert property (ce_i && aw_held_r && !w_held_r
    && tmo_cnt_r == tmo_limit - 1'b1 |=> !aw_held_r && tmo_cnt_r == '0)
    else $error("stale half command not discarded");
endmodule // adc_ctrl

// [tb/conv_model.sv]
`timescale 1ns/1ps
// Behavioural modulator and filter that answers conversion starts
module conv_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Control from the block
  input wire logic start_i,
  input wire logic run_i,
  // Bench knobs: stall holds the count, delay sets the conversion length
  input wire logic stall_i,
  input wire logic [7:0] delay_i,
  input wire logic [15:0] base_i,
  // Result towards the block
  output logic done_o,
  output logic [15:0] data_o,
  output logic [15:0] seq_o
);
  logic [7:0] cnt_r;
  logic [15:0] last_r;

  // Outside the valid cycle the bus shows the inverse, never a stale copy
  assign data_o = done_o ? base_i + seq_o : ~last_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i || !run_i) begin
      cnt_r <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_r <= delay_i;
      end else if (cnt_r != 8'h00 && !stall_i) begin
        cnt_r <= cnt_r - 8'h01;
        done_o <= (cnt_r == 8'h01);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      seq_o <= 16'h0000;
      last_r <= 16'h0000;
    end else if (done_o) begin
      seq_o <= seq_o + 16'h0001;
      last_r <= data_o;
    end
  end
endmodule // conv_model

// [tb/adc_conversion_and_input_config_bench.sv]
`timescale 1ns/1ps
// Self-checking bench for the converter control block
module adc_conversion_and_input_config_bench;
  import adc_ctrl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, awvalid, wvalid, bready, arvalid, rready, stall;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, cstart, crun, lowp, turbo, nsup, msup, mref, byp, cdone;
  logic [2:0] rate, gain, ex0, ex1;
  logic [3:0] sel;
  logic [7:0] delay;
  logic [15:0] base, cdata, seq;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  int num_errors = 0, samples_checked = 0, starts = 0, s0;
  cfg_t c;

  always #5 clk = ~clk;

  adc_ctrl #(.TMO_NORMAL_CYC(23'd20), .TMO_TURBO_CYC(23'd20)) i_adc_ctrl (
    .core_clk_i(clk), .reset_i(rst), .ce_i(ce),
    .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb),
    .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp),
    .rvalid_o(rvalid), .rready_i(rready), .conv_done_i(cdone), .conv_data_i(cdata),
    .conv_start_o(cstart), .conv_run_o(crun), .low_power_o(lowp), .rate_o(rate), .turbo_o(turbo),
    .input_select_o(sel), .neg_to_supply_o(nsup), .mon_supply_o(msup), .mon_ref_o(mref),
    .gain_o(gain), .amp_bypass_o(byp), .exc0_route_o(ex0), .exc1_route_o(ex1));

  conv_model i_conv_model (
    .core_clk_i(clk), .reset_i(rst), .start_i(cstart), .run_i(crun), .stall_i(stall),
    .delay_i(delay), .base_i(base), .done_o(cdone), .data_o(cdata), .seq_o(seq));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Write: both channels offered together, each released once taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
    logic pa, pw, pb, ta, tw, tb;
    int n;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    n = 0;
    exp_b.push_back(e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((pa || pw || pb) && n < 200) begin
      @(negedge clk);
      ta = pa && awready;
      tw = pw && wready;
      tb = pb && bvalid;
      @(posedge clk);
      if (ta) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
      if (tb) begin
        bready <= 1'b0;
        pb = 1'b0;
      end
      n++;
    end
    if (n >= 200) chk("write_wait", 32'h0, 32'h1);
    // Idle edge so the next call never reassigns a just-released signal
    @(posedge clk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
    logic pa, pr, ta, tr;
    int n;
    pa = 1'b1;
    pr = 1'b1;
    n = 0;
    exp_r.push_back({e, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while ((pa || pr) && n < 200) begin
      @(negedge clk);
      ta = pa && arready;
      tr = pr && rvalid;
      @(posedge clk);
      if (ta) begin
        arvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tr) begin
        rready <= 1'b0;
        pr = 1'b0;
      end
      n++;
    end
    if (n >= 200) chk("read_wait", 32'h0, 32'h1);
    @(posedge clk);
  endtask

  // Answers are compared in the cycle before the edge that takes them
  always @(negedge clk) begin
    if (bvalid && bready) chk("bresp", 32'(exp_b.pop_front()), 32'(bresp));
    if (rvalid && rready) begin
      chk("rresp", 32'(exp_r[0][33:32]), 32'(rresp));
      if (exp_r[0][33:32] == RESP_OKAY) chk("rdata", exp_r[0][31:0], rdata);
      void'(exp_r.pop_front());
    end
    if (cstart) starts++;
  end

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (!lowp && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) chk("idle_wait", 32'h0, 32'h1);
    repeat (2) @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #200us;
    num_errors++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, stall} = '0;
    {awaddr, araddr, wdata} = '0;
    delay = 8'h06;
    s0 = $urandom(32'h78FE);
    base = 16'($urandom);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_CONFIG, 32'h0, RESP_OKAY);
    rd(ADDR_STATUS, 32'h4, RESP_OKAY);
    rd(ADDR_RESULT, 32'h0, RESP_OKAY);
    rd(ADDR_COMMAND, 32'h0, RESP_OKAY);
    rd(5'h14, 32'h0, RESP_SLVERR);
    wr(5'h18, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(ADDR_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
    rd(ADDR_STATUS, 32'h4, RESP_OKAY);
    // Enable low: readies drop and the sequencer stays put
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ce_freeze", 32'h1, {awready, wready, arready, crun, lowp});
    ce <= 1'b1;
    @(posedge clk);
    $display("test reset_and_map done");
    for (int i = 0; i < 16; i++) begin
      c = CFG_RESET;
      c.input_select_field = 4'(i);
      c.gain = 3'(i);
      c.amp_bypass_bit = 1'b1;
      c.rate = 3'($urandom);
      c.turbo = 1'($urandom);
      wr(ADDR_CONFIG, 32'(c), RESP_OKAY);
      rd(ADDR_CONFIG, 32'(c), RESP_OKAY);
      rd(ADDR_STATUS, {28'h0, c.gain <= GAIN_BYPASS_MAX, 3'h4}, RESP_OKAY);
      chk("select", {4'(i), 1'(i >= SEL_SE_FIRST && i <= SEL_SE_LAST), 1'(i == SEL_MON_SUPPLY),
        1'(i == SEL_MON_REF)}, {sel, nsup, msup, mref});
      chk("gain", {3'(i), 1'(c.gain <= GAIN_BYPASS_MAX)}, {gain, byp});
      chk("rate", {c.rate, c.turbo}, {rate, turbo});
    end
    $display("test input_config done");
    for (int r = 0; r < 7; r++) begin
      wr(ADDR_EXCITE, 32'({3'(6 - r), 3'(r)}), RESP_OKAY);
      rd(ADDR_EXCITE, 32'({3'(6 - r), 3'(r)}), RESP_OKAY);
      chk("excite", {3'(r), 3'(6 - r)}, {ex0, ex1});
    end
    $display("test excitation done");
    wr(ADDR_CONFIG, 32'h0, RESP_OKAY);
    starts = 0;
    wr(ADDR_COMMAND, 32'(CMD_START), RESP_OKAY);
    wait_idle();
    repeat (20) @(posedge clk);
    chk("single_count", 32'h0001_0001, {seq, 16'(starts)});
    chk("single_idle", 32'h1, {crun, lowp});
    rd(ADDR_STATUS, 32'h6, RESP_OKAY);
    rd(ADDR_RESULT, 32'(base), RESP_OKAY);
    rd(ADDR_STATUS, 32'h4, RESP_OKAY);
    $display("test single_shot done");
    c = CFG_RESET;
    c.continuous = 1'b1;
    c.rate = 3'h5;
    delay <= 8'h03;
    wr(ADDR_CONFIG, 32'(c), RESP_OKAY);
    starts = 0;
    s0 = int'(seq);
    wr(ADDR_COMMAND, 32'(CMD_START), RESP_OKAY);
    for (int n = 0; n < 300 && int'(seq) < s0 + 5; n++) @(posedge clk);
    stall <= 1'b1;
    repeat (4) @(posedge clk);
    chk("cont_starts", 32'(int'(seq) - s0 + 1), 32'(starts));
    chk("cont_count", 32'h5, 32'(int'(seq) - s0));
    chk("cont_rate", 32'h5, 32'(rate));
    rd(ADDR_RESULT, 32'(16'(base + seq - 16'h0001)), RESP_OKAY);
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    wr(ADDR_COMMAND, 32'(CMD_POWERDOWN), RESP_OKAY);
    stall <= 1'b0;
    repeat (3) @(posedge clk);
    chk("powerdown", 32'h1, {crun, lowp});
    $display("test continuous done");
    for (int k = 4; k < 7; k++) wr(ADDR_COMMAND, 32'(k), RESP_OKAY);
    rd(ADDR_CONFIG, 32'(c), RESP_OKAY);
    wr(ADDR_COMMAND, 32'(CMD_RESET), RESP_OKAY);
    rd(ADDR_CONFIG, 32'h0, RESP_OKAY);
    $display("test commands done");
    // Stale half write to an unmapped address must be dropped before the next write
    awaddr <= 5'h18;
    awvalid <= 1'b1;
    @(posedge clk);
    awvalid <= 1'b0;
    repeat (25) @(posedge clk);
    wr(ADDR_CONFIG, 32'h0000_0123, RESP_OKAY);
    rd(ADDR_CONFIG, 32'h0000_0123, RESP_OKAY);
    $display("test timeout done");
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule // adc_conversion_and_input_config_bench
